/* File: hdl/pueg_pkg.sv */
// Package holding the register map, field layout and reset values of the protection unit bank.
package pueg_pkg;
    localparam logic [11:0] OFS_RAM_EVENT       = 12'h100;
    localparam logic [11:0] OFS_FLASH_EVENT     = 12'h104;
    localparam logic [11:0] OFS_PERIPH_EVENT    = 12'h108;
    localparam logic [11:0] OFS_RAM_PUBLISH     = 12'h180;
    localparam logic [11:0] OFS_FLASH_PUBLISH   = 12'h184;
    localparam logic [11:0] OFS_PERIPH_PUBLISH  = 12'h188;
    localparam logic [11:0] OFS_IRQ_ENABLE      = 12'h300;
    localparam logic [11:0] OFS_IRQ_ENABLE_SET  = 12'h304;
    localparam logic [11:0] OFS_IRQ_ENABLE_CLR  = 12'h308;
    localparam logic [11:0] OFS_FEATURES        = 12'h400;
    localparam logic [11:0] OFS_EXT_DOMAIN      = 12'h440;
    localparam logic [11:0] OFS_CHAN_SEC        = 12'h480;
    localparam logic [11:0] OFS_CHAN_SEC_LOCK   = 12'h484;
    localparam logic [11:0] OFS_PIN_SEC         = 12'h4c0;
    localparam logic [11:0] OFS_PIN_SEC_LOCK    = 12'h4c4;
    localparam logic [11:0] OFS_FLASH_NSC_SEL   = 12'h500;
    localparam logic [11:0] OFS_FLASH_NSC_SIZE  = 12'h504;
    localparam logic [11:0] OFS_RAM_NSC_SEL     = 12'h540;
    localparam logic [11:0] OFS_RAM_NSC_SIZE    = 12'h544;
    localparam logic [11:0] OFS_FLASH_REGION    = 12'h600;
    localparam logic [11:0] OFS_RAM_REGION      = 12'h700;
    localparam logic [11:0] OFS_PERIPH_RIGHTS   = 12'h800;
    localparam int          NUM_EVENTS          = 3;
    localparam int          EVT_RAM             = 0;
    localparam int          EVT_FLASH           = 1;
    localparam int          EVT_PERIPH          = 2;
    localparam int          PUB_CHAN_LSB        = 0;
    localparam int          PUB_CHAN_W          = 8;
    localparam int          PUB_EN_BIT          = 31;
    localparam int          NSC_LOCK_BIT        = 8;
    localparam int          NSC_SIZE_W          = 4;
    localparam int          NSC_SEL_W           = 5;
    localparam logic [31:0] PUBLISH_RESET       = 32'h0000_0000;
    localparam logic [2:0]  IRQ_ENABLE_RESET    = 3'h0;
    localparam logic [31:0] PIN_SEC_RESET       = 32'hffff_ffff;
    localparam logic [31:0] CHAN_SEC_RESET      = 32'hffff_ffff;
    localparam logic [31:0] FLASH_REGION_RESET  = 32'h0000_0017;
    localparam logic [31:0] RAM_REGION_RESET    = 32'h0000_0017;
    localparam logic [31:0] FEATURES_VALUE      = 32'h0000_0001;
    localparam logic [31:0] EXT_DOMAIN_VALUE    = 32'h0000_0000;
    localparam logic [31:0] PERIPH_RIGHTS_VALUE = 32'h0000_0000;
endpackage : pueg_pkg

/* File: hdl/pueg_reset_sync.sv */
// Reset release synchroniser for the protection unit bank.
`timescale 1ns/1ps
`default_nettype none
module pueg_reset_sync (
    input  wire logic ref_clk,
    input  wire logic reset_n,
    output var  logic sync_reset_n
);
    logic stage_q;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            stage_q      <= 1'b0;
            sync_reset_n <= 1'b0;
        end else begin
            stage_q      <= 1'b1;
            sync_reset_n <= stage_q;
        end
    end
endmodule : pueg_reset_sync
`default_nettype wire

/* File: hdl/pueg_lock_reg.sv */
// Writable register that a lock bit freezes until the next reset.
`timescale 1ns/1ps
`default_nettype none
module pueg_lock_reg #(
    parameter int          WIDTH = 32,
    parameter logic [31:0] RESET = 32'h0000_0000
) (
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    input  wire logic             wr_en,
    input  wire logic [WIDTH-1:0] wr_data,
    input  wire logic             locked,
    output var  logic [WIDTH-1:0] value_q
);
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            value_q <= RESET[WIDTH-1:0];
        end else if (wr_en && !locked) begin
            value_q <= wr_data;
        end
    end
endmodule : pueg_lock_reg
`default_nettype wire

/* File: hdl/pueg_top.sv */
// Protection unit event, interrupt, publish and security attribute register bank on APB.
//
// Local design decision: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module pueg_top
    import pueg_pkg::*;
#(
    parameter int NSC_COUNT = 2
) (
    input  wire logic                  ref_clk,
    input  wire logic                  reset_n,
    input  wire logic                  retention_reset_n,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [11:0]           paddr,
    input  wire logic [31:0]           pwdata,
    output var  logic [31:0]           prdata,
    output var  logic                  pready,
    output var  logic                  pslverr,
    input  wire logic [NUM_EVENTS-1:0] violation_detect,
    output var  logic                  irq,
    output var  logic [NUM_EVENTS-1:0] publish_strobe,
    output var  logic [PUB_CHAN_W-1:0] publish_channel_index [NUM_EVENTS],
    output var  logic [31:0]           event_interconnect_secure,
    output var  logic [31:0]           pin_secure
);
    logic                  rst_n;
    logic                  rst_ret_n;
    logic                  wr_access;
    logic                  rd_access;
    logic                  addr_hit;
    logic [31:0]           rdata_d;
    logic [NUM_EVENTS-1:0] event_flag_q;
    logic [31:0]           publish_q [NUM_EVENTS];
    logic [NUM_EVENTS-1:0] irq_enable_q;
    logic                  chan_lock_q;
    logic                  pin_lock_q;
    logic [31:0]           chan_sec_q;
    logic [31:0]           pin_sec_q;
    logic [31:0]           flash_nsc_sel_q  [NSC_COUNT];
    logic [31:0]           flash_nsc_size_q [NSC_COUNT];
    logic [31:0]           ram_nsc_sel_q    [NSC_COUNT];
    logic [31:0]           ram_nsc_size_q   [NSC_COUNT];
    logic [31:0]           flash_region_q;
    logic [31:0]           ram_region_q;
    logic                  wr_irq_plain;
    logic                  wr_irq_set;
    logic                  wr_irq_clr;
    logic                  wr_chan_sec;
    logic                  wr_pin_sec;
    logic                  wr_chan_lock;
    logic                  wr_pin_lock;
    logic                  wr_flash_region;
    logic                  wr_ram_region;
    logic [NUM_EVENTS-1:0] wr_event;
    logic [NUM_EVENTS-1:0] wr_publish;
    logic [NSC_COUNT-1:0]  wr_flash_sel;
    logic [NSC_COUNT-1:0]  wr_flash_size;
    logic [NSC_COUNT-1:0]  wr_ram_sel;
    logic [NSC_COUNT-1:0]  wr_ram_size;

    pueg_reset_sync u_rst (
        .ref_clk      (ref_clk),
        .reset_n      (reset_n),
        .sync_reset_n (rst_n)
    );

    pueg_reset_sync u_rst_ret (
        .ref_clk      (ref_clk),
        .reset_n      (retention_reset_n),
        .sync_reset_n (rst_ret_n)
    );

    // Every access completes with no wait state; writes act in the access phase.
    assign wr_access = psel && penable && pwrite;
    assign rd_access = psel && !penable && !pwrite;

    // Write strobes, one per register, taken in the access cycle.
    assign wr_irq_plain    = wr_access && paddr == OFS_IRQ_ENABLE;
    assign wr_irq_set      = wr_access && paddr == OFS_IRQ_ENABLE_SET;
    assign wr_irq_clr      = wr_access && paddr == OFS_IRQ_ENABLE_CLR;
    assign wr_chan_sec     = wr_access && paddr == OFS_CHAN_SEC;
    assign wr_pin_sec      = wr_access && paddr == OFS_PIN_SEC;
    assign wr_chan_lock    = wr_access && paddr == OFS_CHAN_SEC_LOCK && pwdata[0];
    assign wr_pin_lock     = wr_access && paddr == OFS_PIN_SEC_LOCK && pwdata[0];
    assign wr_flash_region = wr_access && paddr == OFS_FLASH_REGION;
    assign wr_ram_region   = wr_access && paddr == OFS_RAM_REGION;

    // Event flags: hardware set wins over a software write of zero.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            event_flag_q <= '0;
        end else begin
            for (int i = 0; i < NUM_EVENTS; i++) begin
                if (violation_detect[i]) begin
                    event_flag_q[i] <= 1'b1;
                end else if (wr_event[i]) begin
                    event_flag_q[i] <= pwdata[0];
                end
            end
        end
    end

    // Publish configuration and one-cycle publish strobe per event.
    for (genvar g = 0; g < NUM_EVENTS; g++) begin : g_pub
        assign wr_event[g]   = wr_access && paddr == OFS_RAM_EVENT + 12'(4 * g);
        assign wr_publish[g] = wr_access && paddr == OFS_RAM_PUBLISH + 12'(4 * g);

        always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
                publish_q[g] <= PUBLISH_RESET;
            end else if (wr_publish[g]) begin
                publish_q[g] <= pwdata & 32'h8000_00ff;
            end
        end

        always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
                publish_strobe[g]        <= 1'b0;
                publish_channel_index[g] <= '0;
            end else begin
                publish_strobe[g]        <= violation_detect[g] && publish_q[g][PUB_EN_BIT];
                publish_channel_index[g] <= publish_q[g][PUB_CHAN_LSB +: PUB_CHAN_W];
            end
        end
    end

    // Interrupt enables reached through the plain, set and clear views.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_enable_q <= IRQ_ENABLE_RESET;
        end else if (wr_irq_plain) begin
            irq_enable_q <= pwdata[NUM_EVENTS-1:0];
        end else if (wr_irq_set) begin
            irq_enable_q <= irq_enable_q | pwdata[NUM_EVENTS-1:0];
        end else if (wr_irq_clr) begin
            irq_enable_q <= irq_enable_q & ~pwdata[NUM_EVENTS-1:0];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(event_flag_q & irq_enable_q);
        end
    end

    // Lock bits are write-one-to-set and only reset clears them.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            chan_lock_q <= 1'b0;
        end else if (wr_chan_lock) begin
            chan_lock_q <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_lock_q <= 1'b0;
        end else if (wr_pin_lock) begin
            pin_lock_q <= 1'b1;
        end
    end

    pueg_lock_reg #(.WIDTH(32), .RESET(CHAN_SEC_RESET)) u_chan_sec (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .wr_en   (wr_chan_sec),
        .wr_data (pwdata),
        .locked  (chan_lock_q),
        .value_q (chan_sec_q)
    );

    // The pin attribute register sits on the retention reset only.
    pueg_lock_reg #(.WIDTH(32), .RESET(PIN_SEC_RESET)) u_pin_sec (
        .ref_clk (ref_clk),
        .rst_n   (rst_ret_n),
        .wr_en   (wr_pin_sec),
        .wr_data (pwdata),
        .locked  (pin_lock_q),
        .value_q (pin_sec_q)
    );

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            event_interconnect_secure <= CHAN_SEC_RESET;
        end else begin
            event_interconnect_secure <= chan_sec_q;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_secure <= PIN_SEC_RESET;
        end else begin
            pin_secure <= pin_sec_q;
        end
    end

    // Callable-area select and size; the size register's lock freezes the pair.
    for (genvar n = 0; n < NSC_COUNT; n++) begin : g_nsc
        assign wr_flash_sel[n]  = wr_access && paddr == OFS_FLASH_NSC_SEL + 12'(8 * n);
        assign wr_flash_size[n] = wr_access && paddr == OFS_FLASH_NSC_SIZE + 12'(8 * n);
        assign wr_ram_sel[n]    = wr_access && paddr == OFS_RAM_NSC_SEL + 12'(8 * n);
        assign wr_ram_size[n]   = wr_access && paddr == OFS_RAM_NSC_SIZE + 12'(8 * n);

        always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
                flash_nsc_sel_q[n]  <= '0;
                flash_nsc_size_q[n] <= '0;
            end else if (!flash_nsc_size_q[n][NSC_LOCK_BIT]) begin
                if (wr_flash_sel[n]) begin
                    flash_nsc_sel_q[n] <= {27'h0, pwdata[NSC_SEL_W-1:0]};
                end
                if (wr_flash_size[n]) begin
                    flash_nsc_size_q[n] <= pwdata & 32'h0000_010f;
                end
            end
        end

        always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
                ram_nsc_sel_q[n]  <= '0;
                ram_nsc_size_q[n] <= '0;
            end else if (!ram_nsc_size_q[n][NSC_LOCK_BIT]) begin
                if (wr_ram_sel[n]) begin
                    ram_nsc_sel_q[n] <= {27'h0, pwdata[NSC_SEL_W-1:0]};
                end
                if (wr_ram_size[n]) begin
                    ram_nsc_size_q[n] <= pwdata & 32'h0000_010f;
                end
            end
        end
    end

    // First flash and RAM region permission words are held as plain storage.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            flash_region_q <= FLASH_REGION_RESET;
        end else if (wr_flash_region) begin
            flash_region_q <= pwdata;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ram_region_q <= RAM_REGION_RESET;
        end else if (wr_ram_region) begin
            ram_region_q <= pwdata;
        end
    end

    // Read mux; unmapped addresses read zero and raise an error.
    always_comb begin
        rdata_d  = 32'h0000_0000;
        addr_hit = 1'b1;
        case (paddr)
            OFS_RAM_EVENT:      rdata_d = {31'h0, event_flag_q[EVT_RAM]};
            OFS_FLASH_EVENT:    rdata_d = {31'h0, event_flag_q[EVT_FLASH]};
            OFS_PERIPH_EVENT:   rdata_d = {31'h0, event_flag_q[EVT_PERIPH]};
            OFS_RAM_PUBLISH:    rdata_d = publish_q[EVT_RAM];
            OFS_FLASH_PUBLISH:  rdata_d = publish_q[EVT_FLASH];
            OFS_PERIPH_PUBLISH: rdata_d = publish_q[EVT_PERIPH];
            OFS_IRQ_ENABLE,
            OFS_IRQ_ENABLE_SET,
            OFS_IRQ_ENABLE_CLR: rdata_d = {29'h0, irq_enable_q};
            OFS_FEATURES:       rdata_d = FEATURES_VALUE;
            OFS_EXT_DOMAIN:     rdata_d = EXT_DOMAIN_VALUE;
            OFS_CHAN_SEC:       rdata_d = chan_sec_q;
            OFS_CHAN_SEC_LOCK:  rdata_d = {31'h0, chan_lock_q};
            OFS_PIN_SEC:        rdata_d = pin_sec_q;
            OFS_PIN_SEC_LOCK:   rdata_d = {31'h0, pin_lock_q};
            OFS_FLASH_REGION:   rdata_d = flash_region_q;
            OFS_RAM_REGION:     rdata_d = ram_region_q;
            OFS_PERIPH_RIGHTS:  rdata_d = PERIPH_RIGHTS_VALUE;
            default: begin
                addr_hit = 1'b0;
                for (int n = 0; n < NSC_COUNT; n++) begin
                    if (paddr == OFS_FLASH_NSC_SEL + 12'(8 * n)) begin
                        rdata_d  = flash_nsc_sel_q[n];
                        addr_hit = 1'b1;
                    end
                    if (paddr == OFS_FLASH_NSC_SIZE + 12'(8 * n)) begin
                        rdata_d  = flash_nsc_size_q[n];
                        addr_hit = 1'b1;
                    end
                    if (paddr == OFS_RAM_NSC_SEL + 12'(8 * n)) begin
                        rdata_d  = ram_nsc_sel_q[n];
                        addr_hit = 1'b1;
                    end
                    if (paddr == OFS_RAM_NSC_SIZE + 12'(8 * n)) begin
                        rdata_d  = ram_nsc_size_q[n];
                        addr_hit = 1'b1;
                    end
                end
            end
        endcase
    end

    // Read data is registered in the setup cycle so it is valid in access.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable) begin
            prdata <= rd_access ? rdata_d : 32'h0000_0000;
        end
    end

    // The error answer stands in the access cycle only and is low otherwise.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= psel && !penable && !addr_hit;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pready <= 1'b0;
        end else begin
            pready <= psel && !penable;
        end
    end
endmodule : pueg_top
`default_nettype wire

/* File: verif/pueg_sva.sv */
// Checker of the bank's bus answers, event flags, enables and interrupt output.
`timescale 1ns/1ps
`default_nettype none
module pueg_sva
    import pueg_pkg::*;
#(
    parameter int NSC_COUNT = 2
) (
    input wire logic                  ref_clk,
    input wire logic                  reset_n,
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [11:0]           paddr,
    input wire logic [31:0]           pwdata,
    input wire logic [31:0]           prdata,
    input wire logic                  pready,
    input wire logic                  pslverr,
    input wire logic [NUM_EVENTS-1:0] violation_detect,
    input wire logic                  irq,
    input wire logic [NUM_EVENTS-1:0] publish_strobe
);
    logic [NUM_EVENTS-1:0] flag_q;
    logic [NUM_EVENTS-1:0] en_q;
    logic [NUM_EVENTS-1:0] past_flag_q;
    logic [NUM_EVENTS-1:0] past_en_q;
    logic                  wr_acc;
    logic                  rd_acc;
    assign wr_acc = psel && penable && pready && pwrite;
    assign rd_acc = psel && penable && !pwrite;
    // Reference copies of the flags and enables, updated at the same edges as the bank.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            flag_q <= '0;
            en_q <= IRQ_ENABLE_RESET;
        end else begin
            for (int i = 0; i < NUM_EVENTS; i++) begin
                if (wr_acc && paddr == OFS_RAM_EVENT + 12'(4 * i)) begin
                    flag_q[i] <= pwdata[0] | violation_detect[i];
                end else begin
                    flag_q[i] <= flag_q[i] | violation_detect[i];
                end
            end
            if (wr_acc && paddr == OFS_IRQ_ENABLE) en_q <= pwdata[2:0];
            if (wr_acc && paddr == OFS_IRQ_ENABLE_SET) en_q <= en_q | pwdata[2:0];
            if (wr_acc && paddr == OFS_IRQ_ENABLE_CLR) en_q <= en_q & ~pwdata[2:0];
        end
    end
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            past_flag_q <= '0;
            past_en_q <= '0;
        end else begin
            past_flag_q <= flag_q;
            past_en_q <= en_q;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence answer_s;
        psel && penable && pready;
    endsequence
    ready_setup_a: assert property (setup_s |=> answer_s)
        else $error("no answer in the cycle after setup");
    ready_access_a: assert property (pready |-> psel && penable)
        else $error("ready outside an access cycle");
    unmapped_zero_a: assert property (pslverr |-> pready && (pwrite || prdata == 32'h0))
        else $error("error answer not a zero access cycle");
    irq_level_a: assert property (irq == |(past_flag_q & past_en_q))
        else $error("interrupt level disagrees with flags and enables");
    strobe_cause_a: assert property ((publish_strobe & ~$past(violation_detect)) == 3'h0)
        else $error("publish strobe without a detected violation");
    flag_read_a: assert property (rd_acc && paddr inside {12'h100, 12'h104, 12'h108}
        |-> prdata == {31'h0, past_flag_q[paddr[3:2]]}) else $error("event flag read wrong");
    enable_read_a: assert property (rd_acc && paddr inside {12'h300, 12'h304, 12'h308}
        |-> prdata == {29'h0, past_en_q}) else $error("enable read wrong");
    features_read_a: assert property (rd_acc && paddr == OFS_FEATURES |-> prdata == FEATURES_VALUE)
        else $error("features read wrong");
endmodule : pueg_sva
bind pueg_top pueg_sva #(.NSC_COUNT(NSC_COUNT)) u_sva (.ref_clk(ref_clk), .reset_n(reset_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .violation_detect(violation_detect),
    .irq(irq), .publish_strobe(publish_strobe));
`default_nettype wire

/* File: verif/protection_unit_event_regs_bench.sv */
// Self-checking bench of the protection unit event and attribute register bank.
`timescale 1ns/1ps
`default_nettype none
module protection_unit_event_regs_bench;
    import pueg_pkg::*;
    logic        ref_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        retention_reset_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [2:0]  violation_detect = 3'h0;
    logic [31:0] prdata, rdata, ev_sec, pin_sec;
    logic        pready, pslverr, irq, rerr;
    logic [2:0]  publish_strobe;
    logic [7:0]  pci [NUM_EVENTS];
    int          fails = 0;
    int          num_checks = 0;
    pueg_top #(.NSC_COUNT(2)) uut (.ref_clk(ref_clk), .reset_n(reset_n),
        .retention_reset_n(retention_reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .violation_detect(violation_detect), .irq(irq), .publish_strobe(publish_strobe),
        .publish_channel_index(pci), .event_interconnect_secure(ev_sec), .pin_secure(pin_sec));
    always #5 ref_clk = ~ref_clk;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(a, 1'b0, 32'h0);
        check(rdata, exp);
    endtask : rd
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(a, 1'b1, d);
    endtask : wr
    task automatic do_reset(input logic ret);
        reset_n <= 1'b0;
        retention_reset_n <= ~ret;
        repeat (4) @(posedge ref_clk);
        reset_n <= 1'b1;
        retention_reset_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        #1;
    endtask : do_reset
    // Returns just after the edge that sampled the one-cycle detection.
    task automatic pulse(input int i);
        @(posedge ref_clk);
        violation_detect[i] <= 1'b1;
        @(posedge ref_clk);
        violation_detect <= 3'h0;
        #1;
    endtask : pulse
    task automatic test_reset;
        check(pin_sec, PIN_SEC_RESET);
        check(ev_sec, CHAN_SEC_RESET);
        for (int i = 0; i < 3; i++) rd(OFS_RAM_PUBLISH + 12'(4 * i), PUBLISH_RESET);
        rd(OFS_IRQ_ENABLE, 32'h0);
        wr(OFS_FEATURES, 32'h0);
        rd(OFS_FEATURES, FEATURES_VALUE);
        rd(12'h604, 32'h0);
        check({31'h0, rerr}, 32'h1);
        $display("test reset done");
    endtask : test_reset
    task automatic test_enables;
        wr(OFS_IRQ_ENABLE_SET, 32'h5);
        rd(OFS_IRQ_ENABLE, 32'h5);
        wr(OFS_IRQ_ENABLE_SET, 32'h0);
        rd(OFS_IRQ_ENABLE_SET, 32'h5);
        wr(OFS_IRQ_ENABLE_CLR, 32'h4);
        wr(OFS_IRQ_ENABLE_CLR, 32'h0);
        rd(OFS_IRQ_ENABLE_CLR, 32'h1);
        wr(OFS_IRQ_ENABLE, 32'h6);
        rd(OFS_IRQ_ENABLE, 32'h6);
        $display("test enables done");
    endtask : test_enables
    task automatic test_events;
        for (int i = 0; i < NUM_EVENTS; i++) begin
            pulse(i);
            @(posedge ref_clk);
            #1;
            check({31'h0, irq}, {31'h0, 1'(i != 0)});
            rd(OFS_RAM_EVENT + 12'(4 * i), 32'h1);
            wr(OFS_RAM_EVENT + 12'(4 * i), 32'h0);
            rd(OFS_RAM_EVENT + 12'(4 * i), 32'h0);
            check({31'h0, irq}, 32'h0);
        end
        $display("test events done");
    endtask : test_events
    task automatic test_publish;
        for (int i = 0; i < NUM_EVENTS; i++) begin
            wr(OFS_RAM_PUBLISH + 12'(4 * i), 32'h8000_00ff - 32'(i));
            rd(OFS_RAM_PUBLISH + 12'(4 * i), 32'h8000_00ff - 32'(i));
            check({24'h0, pci[i]}, 32'h0000_00ff - 32'(i));
            pulse(i);
            check({29'h0, publish_strobe}, 32'(1 << i));
            wr(OFS_RAM_PUBLISH + 12'(4 * i), 32'h0000_00ff);
            pulse(i);
            check({29'h0, publish_strobe}, 32'h0);
            wr(OFS_RAM_EVENT + 12'(4 * i), 32'h0);
        end
        $display("test publish done");
    endtask : test_publish
    task automatic test_locks;
        wr(OFS_CHAN_SEC, 32'h0000_00a5);
        wr(OFS_CHAN_SEC_LOCK, 32'h1);
        wr(OFS_CHAN_SEC, 32'h0);
        rd(OFS_CHAN_SEC, 32'h0000_00a5);
        wr(OFS_PIN_SEC, 32'h8000_0001);
        wr(OFS_PIN_SEC_LOCK, 32'h1);
        wr(OFS_PIN_SEC, 32'hffff_ffff);
        rd(OFS_PIN_SEC, 32'h8000_0001);
        check(ev_sec, 32'h0000_00a5);
        do_reset(1'b0);
        check(pin_sec, 32'h8000_0001);
        check(ev_sec, CHAN_SEC_RESET);
        wr(OFS_PIN_SEC, 32'h0000_0003);
        rd(OFS_PIN_SEC, 32'h0000_0003);
        do_reset(1'b1);
        check(pin_sec, PIN_SEC_RESET);
        $display("test locks done");
    endtask : test_locks
    task automatic test_nsc;
        logic [11:0] a;
        for (int k = 0; k < 4; k++) begin
            a = ((k % 2) ? OFS_RAM_NSC_SEL : OFS_FLASH_NSC_SEL) + 12'(8 * (k / 2));
            wr(a, 32'h1f);
            wr(a + 12'h4, 32'h0000_0108);
            wr(a, 32'h0);
            wr(a + 12'h4, 32'h0);
            rd(a, 32'h1f);
            rd(a + 12'h4, 32'h0000_0108);
        end
        $display("test callable areas done");
    endtask : test_nsc
    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_sim
    initial begin
        do_reset(1'b1);
        test_reset();
        test_enables();
        test_events();
        test_publish();
        test_locks();
        test_nsc();
        end_sim();
    end
    initial begin
        #100000;
        fails++;
        end_sim();
    end
endmodule : protection_unit_event_regs_bench
`default_nettype wire
